// ### pfre_row_erase.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
module pfre_row_erase #(
  parameter int ERASE_CYCLES = pfre_pkg::PFRE_ERASE_CYCLES,
  parameter logic [21:0] FLASH_BYTES = 22'h008000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic row_protected,
  input wire logic abort_event,
  output logic [15:0] flash_row_addr,
  output logic flash_erase_req,
  output logic cpu_halt,
  output logic done_irq
);

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Hit on a registered write; only the low nibble of the address decodes
  function automatic logic reg_hit_f(input logic pend,
    input logic [3:0] addr, input logic [3:0] off);
    return pend && (addr == off);
  endfunction

  // Array busy in the coming cycle; the registered request and halt both
  // use it, so the two can never drift apart
  function automatic logic erase_live_f(input pfre_pkg::pfre_state_t st,
    input logic fail, input logic ok, input logic abort);
    return (st == pfre_pkg::PFRE_ST_CHECK && !fail) ||
           (st == pfre_pkg::PFRE_ST_ERASE && !ok && !abort);
  endfunction

  // -------------------------------------------------------------------
  // Bus address phase capture
  // -------------------------------------------------------------------
  logic wr_pend_reg;
  logic [3:0] wr_addr_reg;
  logic addr_phase;

  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 4'h0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[3:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // Bus response
  // -------------------------------------------------------------------
  // Zero wait states; every access is OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Write decode
  // -------------------------------------------------------------------
  logic wr_ctrl;
  logic wr_ptr;
  logic wr_unlock;
  pfre_pkg::pfre_ctrl_t wdata_ctrl;

  assign wr_ctrl = reg_hit_f(wr_pend_reg, wr_addr_reg,
                             pfre_pkg::PFRE_OFF_CTRL);
  assign wr_ptr = reg_hit_f(wr_pend_reg, wr_addr_reg,
                            pfre_pkg::PFRE_OFF_TABLE_PTR);
  assign wr_unlock = reg_hit_f(wr_pend_reg, wr_addr_reg,
                               pfre_pkg::PFRE_OFF_UNLOCK);
  assign wdata_ctrl = hwdata[7:0];

  // -------------------------------------------------------------------
  // Unlock sequence
  // -------------------------------------------------------------------
  pfre_pkg::pfre_unlock_t unlock_reg;

  // Any control write consumes the arming, so a stray start later
  // cannot launch an erase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unlock_reg <= pfre_pkg::PFRE_UNL_IDLE;
    end else if (wr_unlock) begin
      case (unlock_reg)
        pfre_pkg::PFRE_UNL_IDLE: begin
          unlock_reg <= (hwdata[7:0] == pfre_pkg::PFRE_UNLOCK_KEY1) ?
                        pfre_pkg::PFRE_UNL_KEY1 : pfre_pkg::PFRE_UNL_IDLE;
        end
        pfre_pkg::PFRE_UNL_KEY1: begin
          unlock_reg <= (hwdata[7:0] == pfre_pkg::PFRE_UNLOCK_KEY2) ?
                        pfre_pkg::PFRE_UNL_ARMED : pfre_pkg::PFRE_UNL_IDLE;
        end
        default: begin
          unlock_reg <= pfre_pkg::PFRE_UNL_IDLE;
        end
      endcase
    end else if (wr_ctrl || wr_ptr) begin
      unlock_reg <= pfre_pkg::PFRE_UNL_IDLE;
    end
  end

  // -------------------------------------------------------------------
  // Launch qualification
  // -------------------------------------------------------------------
  pfre_pkg::pfre_state_t state_reg;
  pfre_pkg::pfre_ctrl_t ctrl_reg;
  logic launch;

  // A launch needs the armed unlock, write enable and erase select, all
  // in the same control write; otherwise the start bit never sets
  assign launch = wr_ctrl && wdata_ctrl.start &&
                  (state_reg == pfre_pkg::PFRE_ST_IDLE) &&
                  (unlock_reg == pfre_pkg::PFRE_UNL_ARMED) &&
                  wdata_ctrl.write_enable_bit &&
                  wdata_ctrl.erase_select;

  // -------------------------------------------------------------------
  // Table pointer and row address
  // -------------------------------------------------------------------
  logic [21:0] table_ptr_reg;
  logic [21:0] row_base;
  logic addr_invalid;
  logic region_bad;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      table_ptr_reg <= 22'h000000;
    end else if (wr_ptr && (state_reg == pfre_pkg::PFRE_ST_IDLE)) begin
      table_ptr_reg <= hwdata[21:0];
    end
  end

  assign row_base = {table_ptr_reg[21:6], 6'h00};
  assign addr_invalid = (row_base >= FLASH_BYTES);
  assign region_bad = (ctrl_reg.memory_region_select !=
                       pfre_pkg::PFRE_REGION_FLASH);

  // Row address is frozen while an erase runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_row_addr <= 16'h0000;
    end else if (state_reg == pfre_pkg::PFRE_ST_IDLE) begin
      flash_row_addr <= table_ptr_reg[21:6];
    end
  end

  // -------------------------------------------------------------------
  // Erase sequencer
  // -------------------------------------------------------------------
  logic [31:0] timer_reg;
  logic timer_done;
  logic check_fail;
  logic erase_ok;
  logic erase_abort;

  assign timer_done = (timer_reg == 32'h00000001);
  assign check_fail = row_protected || addr_invalid || region_bad;
  // An abort in the last cycle wins over completion: the row may be only
  // part erased, so software must see an error and retry
  assign erase_ok = (state_reg == pfre_pkg::PFRE_ST_ERASE) &&
                    timer_done && !abort_event;
  assign erase_abort = (state_reg == pfre_pkg::PFRE_ST_ERASE) &&
                       abort_event;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= pfre_pkg::PFRE_ST_IDLE;
    end else begin
      case (state_reg)
        pfre_pkg::PFRE_ST_IDLE: begin
          if (launch) begin
            state_reg <= pfre_pkg::PFRE_ST_CHECK;
          end
        end
        pfre_pkg::PFRE_ST_CHECK: begin
          // A cycle of its own, so region and row written with the launch
          // have settled before the array is asked for anything
          if (check_fail) begin
            state_reg <= pfre_pkg::PFRE_ST_IDLE;
          end else begin
            state_reg <= pfre_pkg::PFRE_ST_ERASE;
          end
        end
        pfre_pkg::PFRE_ST_ERASE: begin
          if (erase_ok || erase_abort) begin
            state_reg <= pfre_pkg::PFRE_ST_IDLE;
          end
        end
        default: begin
          state_reg <= pfre_pkg::PFRE_ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Erase timer
  // -------------------------------------------------------------------
  // Self-timed: only the counter or an abort_event ends a running erase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_reg <= 32'h00000000;
    end else if (state_reg == pfre_pkg::PFRE_ST_CHECK) begin
      timer_reg <= 32'(ERASE_CYCLES);
    end else if (state_reg == pfre_pkg::PFRE_ST_ERASE &&
                 timer_reg != 32'h00000000) begin
      timer_reg <= timer_reg - 32'h00000001;
    end
  end

  // -------------------------------------------------------------------
  // Array request and CPU halt
  // -------------------------------------------------------------------
  // Erase strobe to the array; row write latches are not on this path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_erase_req <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      flash_erase_req <= erase_live_f(state_reg, check_fail, erase_ok,
                                      erase_abort);
      cpu_halt <= erase_live_f(state_reg, check_fail, erase_ok,
                               erase_abort);
    end
  end

  // -------------------------------------------------------------------
  // Control register
  // -------------------------------------------------------------------
  logic err_set;

  assign err_set = ((state_reg == pfre_pkg::PFRE_ST_CHECK) &&
                    check_fail) ||
                   erase_abort;

  // Software fields; write enable is never touched by the sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg.memory_region_select <= 2'h0;
      ctrl_reg.erase_select <= 1'b0;
      ctrl_reg.write_enable_bit <= 1'b0;
      ctrl_reg.done_irq_enable <= 1'b0;
    end else if (wr_ctrl && state_reg == pfre_pkg::PFRE_ST_IDLE) begin
      ctrl_reg.memory_region_select <= wdata_ctrl.memory_region_select;
      ctrl_reg.erase_select <= wdata_ctrl.erase_select;
      ctrl_reg.write_enable_bit <= wdata_ctrl.write_enable_bit;
      ctrl_reg.done_irq_enable <= wdata_ctrl.done_irq_enable;
    end
  end

  // -------------------------------------------------------------------
  // Start bit
  // -------------------------------------------------------------------
  // Start is set only by a qualified launch, cleared by hardware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg.start <= 1'b0;
    end else if (launch) begin
      ctrl_reg.start <= 1'b1;
    end else if (err_set || erase_ok) begin
      ctrl_reg.start <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Status flags
  // -------------------------------------------------------------------
  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg.write_error_flag <= 1'b0;
      ctrl_reg.done_irq_flag <= 1'b0;
    end else begin
      if (err_set) begin
        ctrl_reg.write_error_flag <= 1'b1;
      end else if (wr_ctrl && !wdata_ctrl.write_error_flag) begin
        ctrl_reg.write_error_flag <= 1'b0;
      end
      if (erase_ok) begin
        ctrl_reg.done_irq_flag <= 1'b1;
      end else if (wr_ctrl && !wdata_ctrl.done_irq_flag) begin
        ctrl_reg.done_irq_flag <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Interrupt request
  // -------------------------------------------------------------------
  // Request follows the flag one cycle later, gated by its enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_irq <= 1'b0;
    end else begin
      done_irq <= ctrl_reg.done_irq_flag &&
                  ctrl_reg.done_irq_enable;
    end
  end

  // -------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    case (haddr[3:0])
      pfre_pkg::PFRE_OFF_CTRL: rd_mux = {24'h000000, ctrl_reg};
      pfre_pkg::PFRE_OFF_TABLE_PTR: rd_mux = {10'h000, table_ptr_reg};
      pfre_pkg::PFRE_OFF_UNLOCK: rd_mux = {30'h00000000, unlock_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Sampled in the address phase; a write in the preceding data phase
  // is not yet visible to a read launched in that same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= (haddr[31:4] == 28'h0000000) ? rd_mux : 32'h00000000;
    end
  end

endmodule // pfre_row_erase

// ### pfre_pkg.sv
package pfre_pkg;

  // -------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------
  localparam logic [3:0] PFRE_OFF_CTRL = 4'h0;
  localparam logic [3:0] PFRE_OFF_TABLE_PTR = 4'h4;
  localparam logic [3:0] PFRE_OFF_UNLOCK = 4'h8;

  localparam logic [7:0] PFRE_UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] PFRE_UNLOCK_KEY2 = 8'haa;
  localparam logic [1:0] PFRE_REGION_FLASH = 2'h2;

  localparam int PFRE_PTR_W = 22;
  localparam int PFRE_ROW_LSB = 6;
  localparam int PFRE_ROW_W = PFRE_PTR_W - PFRE_ROW_LSB;
  localparam int PFRE_ROW_WORDS = 32;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int PFRE_CLK_MHZ = 20;
  localparam int PFRE_ERASE_TIME_US = 2000;
  localparam int PFRE_ERASE_CYCLES = PFRE_ERASE_TIME_US * PFRE_CLK_MHZ;

  // Control register, bit 7 first
  typedef struct packed {
    logic done_irq_enable;
    logic done_irq_flag;
    logic write_error_flag;
    logic start;
    logic write_enable_bit;
    logic erase_select;
    logic [1:0] memory_region_select;
  } pfre_ctrl_t;

  localparam pfre_ctrl_t PFRE_CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    PFRE_UNL_IDLE,
    PFRE_UNL_KEY1,
    PFRE_UNL_ARMED
  } pfre_unlock_t;

  typedef enum logic [1:0] {
    PFRE_ST_IDLE,
    PFRE_ST_CHECK,
    PFRE_ST_ERASE
  } pfre_state_t;

endpackage

// ### pfre_row_erase_assertions.sv
module pfre_row_erase_assertions #(
  parameter int ERASE_CYCLES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic abort_event,
  input logic hreadyout,
  input logic hresp,
  input logic [15:0] flash_row_addr,
  input logic flash_erase_req,
  input logic cpu_halt,
  input logic done_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----
  // Erase length counter
  // ----
  logic [31:0] run_cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_cnt_reg <= 32'h0;
    end else if (flash_erase_req) begin
      run_cnt_reg <= run_cnt_reg + 32'h1;
    end else begin
      run_cnt_reg <= 32'h0;
    end
  end

  chk_halt_with_req: assert property (cpu_halt == flash_erase_req)
    else $error("halt differs from erase request");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_row_frozen: assert property (
    flash_erase_req && $past(flash_erase_req) |-> $stable(flash_row_addr))
    else $error("row address moved during erase");
  chk_erase_bound: assert property (run_cnt_reg <= ERASE_CYCLES)
    else $error("erase ran too long");
  chk_erase_full: assert property (
    $fell(flash_erase_req) |-> run_cnt_reg == ERASE_CYCLES
      || $past(abort_event))
    else $error("erase ended early without abort");
  chk_abort_stop: assert property (
    flash_erase_req && abort_event |=> !flash_erase_req)
    else $error("abort did not end erase");
  chk_launch_cause: assert property (
    $rose(flash_erase_req) |-> $past(hsel && htrans[1] && hwrite
      && haddr == 32'h0, 3) && $past(hwdata[4:2], 2) == 3'h7)
    else $error("erase without control launch");
  chk_irq_quiet: assert property ($rose(done_irq) |-> !cpu_halt)
    else $error("interrupt raised during erase");
endmodule // pfre_row_erase_assertions

bind pfre_row_erase pfre_row_erase_assertions #(
  .ERASE_CYCLES(ERASE_CYCLES)
) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .abort_event(abort_event), .hreadyout(hreadyout), .hresp(hresp),
  .flash_row_addr(flash_row_addr), .flash_erase_req(flash_erase_req),
  .cpu_halt(cpu_halt), .done_irq(done_irq)
);

// ### pfre_row_erase_bench.sv
module pfre_row_erase_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short erase keeps the run brief
  localparam int EC = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic row_protected = 1'b0;
  logic abort_event = 1'b0;
  logic [31:0] hrdata;
  logic [15:0] flash_row_addr;
  logic hreadyout, hresp, flash_erase_req, cpu_halt, done_irq;
  logic [31:0] rd;
  int failures = 0;
  int n_checks = 0;

  always #25 hclk = ~hclk;

  pfre_row_erase #(.ERASE_CYCLES(EC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .row_protected(row_protected),
    .abort_event(abort_event), .flash_row_addr(flash_row_addr),
    .flash_erase_req(flash_erase_req), .cpu_halt(cpu_halt),
    .done_irq(done_irq)
  );

  // ----
  // Checking and bus tasks
  // ----
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 16) begin
        failures++;
        close_out;
      end
      @(posedge hclk);
    end
  endtask

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= wr;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    rd = hrdata;
  endtask

  // Launch, watch the erase window, then read back the control word
  task run(input logic [21:0] p, input logic [7:0] c, input bit un,
           input int ab, input int ncyc, input logic [7:0] ec,
           input logic irq);
    int k;
    int n;
    bus(1'b1, pfre_pkg::PFRE_OFF_TABLE_PTR, {10'h0, p});
    if (un) begin
      bus(1'b1, pfre_pkg::PFRE_OFF_UNLOCK,
          {24'h0, pfre_pkg::PFRE_UNLOCK_KEY1});
      bus(1'b1, pfre_pkg::PFRE_OFF_UNLOCK,
          {24'h0, pfre_pkg::PFRE_UNLOCK_KEY2});
    end
    bus(1'b1, pfre_pkg::PFRE_OFF_CTRL, {24'h0, c});
    k = 0;
    n = 0;
    while (cpu_halt !== 1'b1 && k < 6) begin
      @(posedge hclk);
      k++;
    end
    while (cpu_halt === 1'b1 && n < 100) begin
      if (n == 1) chk({16'h0, flash_row_addr}, {16'h0, p[21:6]});
      if (n == 1) chk({31'h0, flash_erase_req}, 32'h1);
      if (n == ab) abort_event <= 1'b1;
      @(posedge hclk);
      n++;
    end
    abort_event <= 1'b0;
    chk(32'(n), 32'(ncyc));
    repeat (2) @(posedge hclk);
    chk({31'h0, done_irq}, {31'h0, irq});
    bus(1'b0, pfre_pkg::PFRE_OFF_CTRL, 32'h0);
    chk(rd, {24'h0, ec});
    $display("test done, control %h", c);
  endtask

  // ----
  // Scenarios
  // ----
  task t_reset;
    bus(1'b0, pfre_pkg::PFRE_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, pfre_pkg::PFRE_OFF_UNLOCK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    $display("test done, reset and unmapped");
  endtask
  task t_good;
    run(22'h01a7f, 8'h9e, 1'b1, -1, EC, 8'hce, 1'b1);
  endtask
  task t_noirq;
    run(22'h00040, 8'h1e, 1'b1, -1, EC, 8'h4e, 1'b0);
  endtask
  task t_nolock;
    run(22'h00080, 8'h1e, 1'b0, -1, 0, 8'h0e, 1'b0);
  endtask
  task t_nowren;
    run(22'h00080, 8'h16, 1'b1, -1, 0, 8'h06, 1'b0);
  endtask
  task t_noerase;
    run(22'h00080, 8'h1a, 1'b1, -1, 0, 8'h0a, 1'b0);
  endtask
  task t_region;
    run(22'h00080, 8'h1d, 1'b1, -1, 0, 8'h2d, 1'b0);
  endtask
  task t_prot;
    row_protected <= 1'b1;
    run(22'h000c0, 8'h1e, 1'b1, -1, 0, 8'h2e, 1'b0);
    row_protected <= 1'b0;
  endtask
  task t_badaddr;
    run(22'h08000, 8'h1e, 1'b1, -1, 0, 8'h2e, 1'b0);
  endtask
  task t_abort;
    run(22'h00100, 8'h9e, 1'b1, 2, 4, 8'hae, 1'b0);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_nolock;
    t_good;
    t_noirq;
    t_nowren;
    t_noerase;
    t_region;
    t_prot;
    t_badaddr;
    t_abort;
    close_out;
  end
endmodule // pfre_row_erase_bench
